// ==== common/psc_pkg.sv ====
// Package: constants and types shared by the power stage control ends
package psc_pkg;
   // Switching frame length in system clock cycles, 360 degrees
   localparam int unsigned FRAME_CYCLES = 360;
   localparam logic [8:0] FRAME_LAST = 9'h167;
   // Phase offsets in degrees, one picked per output A+, A-, B+, B-
   localparam logic [8:0] PH_0 = 9'h000;
   localparam logic [8:0] PH_30 = 9'h01e;
   localparam logic [8:0] PH_60 = 9'h03c;
   localparam logic [8:0] PH_90 = 9'h05a;
   localparam logic [8:0] PH_120 = 9'h078;
   localparam logic [8:0] PH_180 = 9'h0b4;
   localparam logic [8:0] PH_210 = 9'h0d2;
   localparam logic [8:0] PH_240 = 9'h0f0;
   localparam logic [8:0] PH_270 = 9'h10e;
   localparam logic [8:0] PH_300 = 9'h12c;
   // Default duty in degrees of high time (idle, 50 percent)
   localparam logic [8:0] DUTY_IDLE = 9'h0b4;
   localparam logic [8:0] CNT_RESET = 9'h000;
   localparam int unsigned NUM_OUT = 4;

   typedef enum logic [1:0] {
      PSC_MASTER,
      PSC_SLAVE_ONE,
      PSC_SLAVE_TWO
   } psc_role_type;

   typedef enum logic {
      PSC_BRIDGE,
      PSC_PARALLEL
   } psc_cfg_type;
endpackage : psc_pkg

// ==== common/psc_if.sv ====
// Interface: pins between the power stage and the system controller
interface psc_if;
   logic trim_to_supply; // Rate trim pin tied to digital supply
   logic reset_n; // Active low device reset
   logic sync_pos_in; // Differential sync clock pins into device
   logic sync_neg_in;
   logic shutdown_n_o; // Shutdown flag open-drain pull data
   logic shutdown_n_oe;
   logic warn_n_o; // Warning open-drain pull data
   logic warn_n_oe;
   logic [3:0] out_hiz; // Per output high impedance
   logic [3:0] out_level; // Half-bridge switching levels
   logic shutdown_n; // Resolved open-drain levels
   logic warn_n;
   assign shutdown_n = shutdown_n_oe ? shutdown_n_o : 1'b1;
   assign warn_n = warn_n_oe ? warn_n_o : 1'b1;

   modport device (
      input trim_to_supply, reset_n, sync_pos_in, sync_neg_in,
      output shutdown_n_o, shutdown_n_oe, warn_n_o, warn_n_oe, out_hiz, out_level
   );
   modport ctrl (
      output trim_to_supply, reset_n, sync_pos_in, sync_neg_in,
      input shutdown_n, warn_n, out_hiz, out_level
   );
endinterface : psc_if

// ==== core/psc_phase_gen.sv ====
// Phase generator: one half-bridge level per output from frame counter
module psc_phase_gen
   import psc_pkg::*;
(
   input wire logic [8:0] frame_cnt_i, // Frame position in degrees
   input wire logic [8:0] offset_i [NUM_OUT], // Per output phase offset
   input wire logic [NUM_OUT-1:0] hiz_i, // Per output shutdown
   output logic [NUM_OUT-1:0] level_o // Switching levels
);
   genvar g;
   // Each output goes high for DUTY_IDLE degrees starting at its offset
   generate
      for (g = 0; g < NUM_OUT; g++) begin : g_out
         logic [9:0] rel;
         logic [8:0] pos;
         assign rel = {1'b0, frame_cnt_i} + 10'h168 - {1'b0, offset_i[g]};
         assign pos = (rel >= 10'h168) ? 9'(rel - 10'h168) : rel[8:0];
         assign level_o[g] = !hiz_i[g] && (pos < DUTY_IDLE);
      end
   endgenerate
endmodule : psc_phase_gen

// ==== core/psc_device.sv ====
// Device end: oscillator sync, phase offsets and fault control
// Operation
// - Trim pin at supply selects slave, external clock
// - Straight sync wiring selects slave mode one
// - Crossed sync wiring selects slave mode two
// - Device adds inter-channel delay, audio unchanged
// - Master offsets 0/180/60/240, parallel 0/180/0/180
// - Slave one 60..300, slave two 30..270 offsets
// - Several slaves alternate modes between neighbours
// - Change oscillator setting only during reset
// - Fault: outputs high impedance, shutdown flag low
// - Non latched faults recover; overload, thermal latch
// - Bridge: per channel shutdown; parallel: all four
// - Bootstrap undervoltage: that half-bridge only, silent
// - Both report outputs active low open drain
// - Warning low while above warning temperature
// - Shutdown low on thermal, overload, undervoltage
// - Reset held low forces shutdown flag high
// - Controller lowers volume on warning
// - Latched thermal error held until reset
module psc_device
   import psc_pkg::*;
(
   input wire logic clk_sys_i, // System clock, 250 MHz
   input wire logic reset_i, // Synchronous active high reset
   psc_if.device pins, // Pins toward the controller
   input wire logic parallel_mode_i, // Output configuration, 1 is parallel
   input wire logic sync_wired_cross_i, // Sync pins wired crosswise to master
   input wire logic hot_warn_i, // Junction above warning level
   input wire logic hot_error_i, // Junction above shutdown level
   input wire logic [3:0] overload_i, // Per output overload detected
   input wire logic undervolt_i, // Supply undervoltage
   input wire logic [3:0] local_err_i, // Per output self clearing local error
   input wire logic [3:0] boot_uv_i, // Per output bootstrap undervoltage
   output logic [1:0] role_o, // Current role
   output logic sync_pos_o, // Master drives differential sync
   output logic sync_neg_o // Complement of sync_pos_o on a master, held low on a slave
);
   psc_role_type role_r;
   logic [8:0] frame_cnt_r;
   logic hot_latch_r;
   logic [3:0] ovl_latch_r;
   logic sync_prev_r;
   logic [8:0] offset [NUM_OUT];
   logic [3:0] chan_err;
   logic [3:0] hiz;
   logic [3:0] level;
   logic running;
   logic global_off;
   logic shut_fault;
   logic sync_rise;
   logic sync_edge;
   logic frame_wrap;

   // Role caught while the reset pin is low only
   // A live strap change would otherwise glitch every phase offset
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         role_r <= PSC_MASTER;
      end else if (!pins.reset_n) begin
         if (!pins.trim_to_supply) begin
            role_r <= PSC_MASTER;
         end else if (sync_wired_cross_i) begin
            role_r <= PSC_SLAVE_TWO;
         end else begin
            role_r <= PSC_SLAVE_ONE;
         end
      end
   end

   // Switching runs only while the reset pin is released
   assign running = pins.reset_n;

   // Slave frame restarts on the rising edge of its differential sync clock
   // Both legs must agree, so one stuck leg gives no false frame start
   assign sync_rise = pins.sync_pos_in && !pins.sync_neg_in;
   assign sync_edge = sync_rise && !sync_prev_r;

   // Previous sync level for edge detection
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         sync_prev_r <= 1'b0;
      end else begin
         sync_prev_r <= sync_rise;
      end
   end

   // Natural end of a frame; a slave also wraps here if its sync goes quiet
   assign frame_wrap = (frame_cnt_r == FRAME_LAST);

   // Frame counter; held at zero in reset so offsets restart cleanly
   // A slave trades a short first frame for lock to the master's edge
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || !running) begin
         frame_cnt_r <= CNT_RESET;
      end else if (role_r != PSC_MASTER && sync_edge) begin
         frame_cnt_r <= CNT_RESET;
      end else if (frame_wrap) begin
         frame_cnt_r <= CNT_RESET;
      end else begin
         frame_cnt_r <= frame_cnt_r + 9'h001;
      end
   end

   // Master drives its frame start out as a half-frame square wave
   // Slaves keep both legs low so they never fight the master's clock
   assign sync_pos_o = (role_r == PSC_MASTER) && (frame_cnt_r < PH_180);
   assign sync_neg_o = (role_r == PSC_MASTER) && !(frame_cnt_r < PH_180);

   // Offsets only move switch timing; duty stays untouched
   always_comb begin
      unique case (role_r)
         PSC_MASTER: begin
            offset[0] = PH_0;
            offset[1] = PH_180;
            offset[2] = parallel_mode_i ? PH_0 : PH_60;
            offset[3] = parallel_mode_i ? PH_180 : PH_240;
         end
         // Straight wiring: offsets shifted by 60 degrees
         PSC_SLAVE_ONE: begin
            offset[0] = PH_60;
            offset[1] = PH_240;
            offset[2] = parallel_mode_i ? PH_60 : PH_120;
            offset[3] = parallel_mode_i ? PH_240 : PH_300;
         end
         // Crossed wiring: offsets shifted by 30 degrees
         PSC_SLAVE_TWO: begin
            offset[0] = PH_30;
            offset[1] = PH_210;
            offset[2] = parallel_mode_i ? PH_30 : PH_90;
            offset[3] = parallel_mode_i ? PH_210 : PH_270;
         end
         // Unused role code falls back to master bridge offsets
         default: begin
            offset[0] = PH_0;
            offset[1] = PH_180;
            offset[2] = PH_60;
            offset[3] = PH_240;
         end
      endcase
   end

   // Thermal latch; only the reset pin or reset_i clears it
   // A die that is still hot sets it again once reset is released
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || !pins.reset_n) begin
         hot_latch_r <= 1'b0;
      end else if (hot_error_i) begin
         hot_latch_r <= 1'b1;
      end
   end

   // Overload latch per output; a shorted half-bridge stays off until reset
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || !pins.reset_n) begin
         ovl_latch_r <= 4'h0;
      end else begin
         ovl_latch_r <= ovl_latch_r | overload_i;
      end
   end

   // Shutdown grouping per output configuration
   always_comb begin
      logic [3:0] err;
      err = ovl_latch_r | overload_i | local_err_i;
      if (parallel_mode_i) begin
         chan_err = {4{|err}};
      end else begin
         chan_err = {{2{|err[3:2]}}, {2{|err[1:0]}}};
      end
   end

   // Faults that stop the whole stage regardless of configuration
   assign global_off = !running || hot_latch_r || hot_error_i || undervolt_i;

   // Global faults and per-output errors force high impedance at once
   // Bootstrap undervoltage only touches its own half-bridge
   assign hiz = {4{global_off}} | chan_err | boot_uv_i;

   // Shutdown reasons; held reset and bootstrap undervoltage are not reasons
   assign shut_fault = hot_latch_r || hot_error_i || undervolt_i || (|ovl_latch_r) || (|overload_i)
      || (|local_err_i);

   // Levels come straight from the shared counter, so all outputs stay in step
   // Shutdown gating sits inside the generator to keep a forced-off output low
   psc_phase_gen u_phase (
      .frame_cnt_i(frame_cnt_r),
      .offset_i(offset),
      .hiz_i(hiz),
      .level_o(level)
   );

   // Open-drain style: drive low only, pull-up elsewhere
   assign pins.shutdown_n_o = 1'b0;
   assign pins.shutdown_n_oe = pins.reset_n && shut_fault;
   assign pins.warn_n_o = 1'b0;
   // Warning follows temperature even in reset, the controller may still act
   assign pins.warn_n_oe = hot_warn_i;
   // Status toward the pins and the host
   assign pins.out_hiz = hiz;
   assign pins.out_level = level;
   assign role_o = role_r;
endmodule : psc_device

// ==== core/psc_ctrl.sv ====
// Controller end: reset, role straps, sync relay and volume backoff
module psc_ctrl
   import psc_pkg::*;
(
   input wire logic clk_sys_i, // System clock
   input wire logic reset_i, // Synchronous active high reset
   psc_if.ctrl pins, // Pins toward the device
   input wire logic make_slave_i, // Request slave role
   input wire logic cross_wire_i, // Relay master sync crosswise
   input wire logic master_sync_i, // Master sync clock positive
   input wire logic amp_reset_req_i, // Hold device in reset
   input wire logic trim_change_req_i, // Wish to change oscillator trim
   output logic trim_change_ok_o, // Trim change allowed now
   output logic vol_reduce_o, // Ask audio path to lower volume
   output logic fault_seen_o // Shutdown flag observed low
);
   logic reset_n_r;
   logic vol_reduce_r;
   logic fault_r;

   // Reset pin held low on request; latched faults clear here
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) reset_n_r <= 1'b0;
      else reset_n_r <= !amp_reset_req_i;
   end

   // Trim pin strap and sync wiring
   assign pins.trim_to_supply = make_slave_i;
   assign pins.sync_pos_in = cross_wire_i ? !master_sync_i : master_sync_i;
   assign pins.sync_neg_in = !pins.sync_pos_in;
   assign pins.reset_n = reset_n_r;
   assign trim_change_ok_o = trim_change_req_i && !reset_n_r;

   // Warning steers volume backoff
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         vol_reduce_r <= 1'b0;
         fault_r <= 1'b0;
      end else begin
         vol_reduce_r <= !pins.warn_n;
         fault_r <= !pins.shutdown_n;
      end
   end
   assign vol_reduce_o = vol_reduce_r;
   assign fault_seen_o = fault_r;
endmodule : psc_ctrl

// ==== dv/psc_properties.sv ====
// Checker: pin relations between the two power stage ends
module psc_properties (
   input wire logic clk_sys_i, // System clock
   input wire logic reset_i, // Sync reset
   input wire logic reset_n, // Device reset pin
   input wire logic trim_to_supply, // Slave strap
   input wire logic shutdown_n_o, // Flag pull data
   input wire logic shutdown_n_oe, // Flag drive enable
   input wire logic warn_n_o, // Warning pull data
   input wire logic warn_n_oe, // Warning drive enable
   input wire logic shutdown_n, // Resolved flag
   input wire logic [3:0] out_hiz, // Output high impedance
   input wire logic [3:0] out_level // Switching levels
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   // Reset pin and flag
   property p_flag_rst; !reset_n |-> shutdown_n; endproperty
   a_flag_rst: assert property (p_flag_rst) else $error("flag low in reset");
   property p_hiz_rst; !reset_n |-> out_hiz == 4'hf; endproperty
   a_hiz_rst: assert property (p_hiz_rst) else $error("output driven in reset");
   // Open drain: enable only ever pulls low
   property p_flag_od; shutdown_n_oe |-> !shutdown_n_o; endproperty
   a_flag_od: assert property (p_flag_od) else $error("flag driven high");
   property p_warn_od; warn_n_oe |-> !warn_n_o; endproperty
   a_warn_od: assert property (p_warn_od) else $error("warning driven high");
   property p_fault_hiz; reset_n && !shutdown_n |-> out_hiz != 4'h0; endproperty
   a_fault_hiz: assert property (p_fault_hiz) else $error("fault with all outputs live");
   // Halves of a channel sit half a frame apart at fixed duty
   property p_a_pair; out_hiz[1:0] == 2'h0 |-> out_level[1] != out_level[0]; endproperty
   a_a_pair: assert property (p_a_pair) else $error("channel a halves not opposed");
   property p_b_pair; out_hiz[3:2] == 2'h0 |-> out_level[3] != out_level[2]; endproperty
   a_b_pair: assert property (p_b_pair) else $error("channel b halves not opposed");
   // Master only: slave frames may be cut short by a resync
   property p_half;
      disable iff (reset_i || !reset_n) $rose(out_level[0]) && !out_hiz[0] && !trim_to_supply
         |-> ##179 (out_level[0] || out_hiz[0]) ##1 (!out_level[0] || out_hiz[0]);
   endproperty
   a_half: assert property (p_half) else $error("half frame length wrong");
   c_all_hiz: cover property (reset_n && out_hiz == 4'hf);
   c_flag_low: cover property (reset_n && !shutdown_n);
   c_warn: cover property (reset_n && warn_n_oe);
endmodule : psc_properties

// ==== dv/test_power_stage_phase_and_fault_control.sv ====
// Testbench: both ends joined, role straps, phase offsets and faults
module test_power_stage_phase_and_fault_control import psc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'b0, reset_i = 1'b1, arq = 1'b1, tcr = 1'b1;
   logic par = 1'b0, crs = 1'b0, hw = 1'b0, he = 1'b0, uv = 1'b0, mk = 1'b0, cw = 1'b0, ms = 1'b0;
   logic [3:0] ol = 4'h0, le = 4'h0, bu = 4'h0;
   logic [1:0] role;
   logic tok, vr, fs, sp, sn;
   int err_total = 0, n_tests = 0, sc = 0;
   psc_if ifc();
   always #2 clk_sys_i = ~clk_sys_i;
   // Master sync square wave, one frame per period
   always @(posedge clk_sys_i) begin
      sc <= (sc == 359) ? 0 : sc + 1;
      ms <= (sc < 180);
   end
   psc_device psc_device_inst (.clk_sys_i, .reset_i, .pins(ifc.device), .parallel_mode_i(par),
      .sync_wired_cross_i(crs), .hot_warn_i(hw), .hot_error_i(he), .overload_i(ol), .undervolt_i(uv),
      .local_err_i(le), .boot_uv_i(bu), .role_o(role), .sync_pos_o(sp), .sync_neg_o(sn));
   psc_ctrl psc_ctrl_inst (.clk_sys_i, .reset_i, .pins(ifc.ctrl), .make_slave_i(mk), .cross_wire_i(cw),
      .master_sync_i(ms), .amp_reset_req_i(arq), .trim_change_req_i(tcr), .trim_change_ok_o(tok),
      .vol_reduce_o(vr), .fault_seen_o(fs));
   psc_properties psc_properties_inst (.clk_sys_i, .reset_i, .reset_n(ifc.reset_n),
      .trim_to_supply(ifc.trim_to_supply), .shutdown_n_o(ifc.shutdown_n_o), .shutdown_n_oe(ifc.shutdown_n_oe),
      .warn_n_o(ifc.warn_n_o), .warn_n_oe(ifc.warn_n_oe), .shutdown_n(ifc.shutdown_n),
      .out_hiz(ifc.out_hiz), .out_level(ifc.out_level));
   task automatic w(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : w
   task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up
   // First rise of each output, counted from the A+ rise
   task automatic phases(input int e1, input int e2, input int e3);
      logic [3:0] p;
      int t[4];
      int i;
      t = '{-1, -1, -1, -1};
      i = 0;
      do begin
         p = ifc.out_level;
         w(1);
         #1;
         i++;
      end while (!(ifc.out_level[0] && !p[0]) && i < 800);
      for (i = 0; i < 360; i++) begin
         for (int k = 0; k < 4; k++) if (ifc.out_level[k] && !p[k] && t[k] < 0) t[k] = i;
         p = ifc.out_level;
         w(1);
         #1;
      end
      chk("a_neg", 9'(t[1]), 9'(e1));
      chk("b_pos", 9'(t[2]), 9'(e2));
      chk("b_neg", 9'(t[3]), 9'(e3));
   endtask : phases
   // Hang guard: a run this long counts as a mismatch
   initial begin
      w(100000);
      err_total++;
      wrap_up;
   end
   initial begin
      w(8);
      reset_i <= 1'b0;
      uv <= 1'b1;
      w(3);
      #1;
      chk("flag_rst", ifc.shutdown_n, 1);
      chk("trim_ok", tok, 1);
      // Master bridge, master parallel, slave one bridge, slave two parallel
      for (int m = 0; m < 4; m++) begin
         w(1);
         arq <= 1'b1;
         uv <= 1'b0;
         mk <= (m > 1);
         cw <= (m == 3);
         crs <= (m == 3);
         par <= m[0];
         w(4);
         arq <= 1'b0;
         w(400);
         #1;
         chk("role", role, 9'(m < 2 ? 0 : m - 1));
         chk("sync_out", 9'(sp ^ sn), 9'(m < 2));
         chk("trim_busy", tok, 0);
         phases(180, m[0] ? 0 : 60, m[0] ? 180 : 240);
         w(1);
         le <= 4'h4;
         w(1);
         #1;
         chk("loc_hiz", ifc.out_hiz, m[0] ? 4'hf : 4'hc);
         chk("loc_flag", ifc.shutdown_n, 0);
         w(1);
         le <= 4'h0;
         w(2);
         #1;
         chk("loc_back", ifc.out_hiz, 0);
      end
      w(1);
      bu <= 4'h2;
      w(1);
      #1;
      chk("boot_hiz", ifc.out_hiz, 4'h2);
      chk("boot_flag", ifc.shutdown_n, 1);
      w(1);
      bu <= 4'h0;
      hw <= 1'b1;
      w(3);
      #1;
      chk("boot_back", ifc.out_hiz, 4'h0);
      chk("warn", ifc.warn_n, 0);
      chk("warn_flag", ifc.shutdown_n, 1);
      chk("vol", vr, 1);
      w(1);
      hw <= 1'b0;
      uv <= 1'b1;
      w(2);
      #1;
      chk("uv_flag", ifc.shutdown_n, 0);
      chk("seen", fs, 1);
      w(1);
      uv <= 1'b0;
      w(2);
      #1;
      chk("uv_back", ifc.shutdown_n, 1);
      // Thermal then overload: pulse, expect latch, clear by reset
      for (int f = 0; f < 2; f++) begin
         w(1);
         he <= (f == 0);
         ol <= f ? 4'h8 : 4'h0;
         w(1);
         he <= 1'b0;
         ol <= 4'h0;
         w(3);
         #1;
         chk("latch_flag", ifc.shutdown_n, 0);
         if (f == 0) chk("hot_hiz", ifc.out_hiz, 4'hf);
         w(1);
         arq <= 1'b1;
         w(3);
         arq <= 1'b0;
         w(3);
         #1;
         chk("clr_flag", ifc.shutdown_n, 1);
         chk("clr_hiz", ifc.out_hiz, 0);
      end
      wrap_up;
   end
endmodule : test_power_stage_phase_and_fault_control
